/* File: pesd_event_core.sv */
// module: event decode, counter restriction, threshold and counter
//
// The implementer's own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module pesd_event_core #(
  parameter int CW = 48
) (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic [3:0] uopsDispThread,
  input  wire logic [3:0] uopsDispCore,
  input  wire logic [3:0] uopsRetired,
  input  wire logic [3:0] retireSlots,
  input  wire logic [3:0] instrRetired,
  input  wire logic [63:0] evt,
  input  wire logic       otherCountersIdle,
  pesd_cfg_if.core        cfg
);
  logic [3:0]    inc;
  logic          valid;
  logic          allowed;
  logic [3:0]    qual;
  logic [CW-1:0] count_reg;
  logic [7:0]    u;

  // evt bit map: see handover; single-occurrence events are one bit each
  always_comb begin
    u     = cfg.unitMask;
    inc   = 4'h0;
    valid = 1'b1;
    case (cfg.evCode)
      pesd_pkg::EV_ITLB: begin
        if (u == 8'h01) inc = {3'h0, evt[0]}; // [R1]
        else valid = 1'b0;
      end
      pesd_pkg::EV_OFFREQ: begin
        if (u == 8'h01) inc = {3'h0, evt[1]}; // [R2]
        else if (u == 8'h04) inc = {3'h0, evt[2]}; // [R2]
        else if (u == 8'h08) inc = {3'h0, evt[3]}; // [R2]
        else valid = 1'b0;
      end
      pesd_pkg::EV_DISP: begin
        if (u == 8'h01) inc = uopsDispThread; // [R3]
        else if (u == 8'h02) inc = uopsDispCore; // [R4]
        else valid = 1'b0;
      end
      pesd_pkg::EV_BUFFUL: begin
        if (u == 8'h01) inc = {3'h0, evt[4]}; // [R5]
        else valid = 1'b0;
      end
      pesd_pkg::EV_PGX: begin
        if (u == 8'h01) inc = {3'h0, evt[5]}; // [R6]
        else valid = 1'b0;
      end
      pesd_pkg::EV_RESP0: begin
        if (u == 8'h01) inc = {3'h0, evt[6]}; // [R7]
        else valid = 1'b0;
      end
      pesd_pkg::EV_RESP1: begin
        if (u == 8'h01) inc = {3'h0, evt[7]}; // [R7]
        else valid = 1'b0;
      end
      pesd_pkg::EV_XFLUSH: begin
        if (u == 8'h01) inc = {3'h0, evt[8]}; // [R8]
        else if (u == 8'h20) inc = {3'h0, evt[9]}; // [R8]
        else valid = 1'b0;
      end
      pesd_pkg::EV_BANK: begin
        if (u == 8'h05) inc = {3'h0, evt[10]}; // [R9]
        else valid = 1'b0;
      end
      pesd_pkg::EV_IRET: begin
        if (u == 8'h00 || u == 8'h01) inc = instrRetired; // [R10]
        else valid = 1'b0;
      end
      pesd_pkg::EV_OTHA: begin
        if (u == 8'h02) inc = {3'h0, evt[11]}; // [R12]
        else if (u == 8'h08) inc = {3'h0, evt[12]}; // [R12]
        else if (u == 8'h10) inc = {3'h0, evt[13]}; // [R12]
        else if (u == 8'h20) inc = {3'h0, evt[14]}; // [R12]
        else valid = 1'b0;
      end
      pesd_pkg::EV_URET: begin
        if (u == 8'h01) inc = uopsRetired; // [R13]
        else if (u == 8'h02) inc = retireSlots; // [R13]
        else valid = 1'b0;
      end
      pesd_pkg::EV_MCLR: begin
        if (u == 8'h02) inc = {3'h0, evt[15]}; // [R14]
        else if (u == 8'h04) inc = {3'h0, evt[16]}; // [R14]
        else if (u == 8'h20) inc = {3'h0, evt[17]}; // [R14]
        else valid = 1'b0;
      end
      pesd_pkg::EV_BRET: begin
        if (u == 8'h00 || u == 8'h04) inc = {3'h0, evt[18]}; // [R15]
        else if (u == 8'h01) inc = {3'h0, evt[19]}; // [R15]
        else if (u == 8'h02) inc = {3'h0, evt[20]}; // [R15]
        else if (u == 8'h08) inc = {3'h0, evt[21]}; // [R15]
        else if (u == 8'h10) inc = {3'h0, evt[22]}; // [R15]
        else if (u == 8'h20) inc = {3'h0, evt[23]}; // [R15]
        else if (u == 8'h40) inc = {3'h0, evt[24]}; // [R15]
        else valid = 1'b0;
      end
      pesd_pkg::EV_BMISP: begin
        if (u == 8'h00 || u == 8'h04) inc = {3'h0, evt[25]}; // [R16]
        else if (u == 8'h01) inc = {3'h0, evt[26]}; // [R16]
        else if (u == 8'h02) inc = {3'h0, evt[27]}; // [R16]
        else if (u == 8'h10) inc = {3'h0, evt[28]}; // [R16]
        else if (u == 8'h20) inc = {3'h0, evt[29]}; // [R16]
        else valid = 1'b0;
      end
      pesd_pkg::EV_FPA: begin
        if (u == 8'h02) inc = {3'h0, evt[30]}; // [R17]
        else if (u == 8'h04) inc = {3'h0, evt[31]}; // [R17]
        else if (u == 8'h08) inc = {3'h0, evt[32]}; // [R17]
        else if (u == 8'h10) inc = {3'h0, evt[33]}; // [R17]
        else if (u == 8'h1e) inc = {3'h0, |evt[33:30]}; // [R17]
        else valid = 1'b0;
      end
      default: valid = 1'b0; // [R18]
    endcase
  end

  // counter binding and filter prerequisite for restricted events
  always_comb begin
    allowed = valid;
    if (cfg.evCode == pesd_pkg::EV_RESP0) begin
      allowed = valid && cfg.counterSel == pesd_pkg::CNT_RESP0
                && cfg.filterOk[0]; // [R7]
    end else if (cfg.evCode == pesd_pkg::EV_RESP1) begin
      allowed = valid && cfg.counterSel == pesd_pkg::CNT_RESP1
                && cfg.filterOk[1]; // [R7]
    end else if (cfg.evCode == pesd_pkg::EV_IRET && u == 8'h01) begin
      // precise variant also waits for the other counters to be quiet
      allowed = valid && cfg.counterSel == pesd_pkg::CNT_PRECISE
                && otherCountersIdle; // [R11]
    end
  end

  // threshold: one per cycle meeting cmask, inverted when asked
  always_comb begin
    if (cfg.cmask == 8'h00) begin
      qual = inc; // [R19]
    end else begin
      qual = {3'h0, // [R3] [R9] [R13]
              (({4'h0, inc} >= cfg.cmask) ^ cfg.thresholdInvert)}; // [R19]
    end
  end

  always_ff @(posedge clk) begin
    if (srst || cfg.countClear) begin
      count_reg <= '0;
    end else if (cfg.enable && allowed) begin
      count_reg <= count_reg + CW'(qual); // [R19]
    end
  end

  assign cfg.count    = 48'(count_reg);
  assign cfg.accepted = allowed;

  bad_event_a: assert property (@(posedge clk) disable iff (srst) // [R18]
    (cfg.enable && !allowed && !cfg.countClear) |=> $stable(count_reg))
    else $error("counter moved on an unaccepted selection");
  resp0_ctr_a: assert property (@(posedge clk) disable iff (srst) // [R7]
    (cfg.evCode == pesd_pkg::EV_RESP0 && cfg.counterSel != 2'h0) |-> !allowed)
    else $error("response event 0 accepted off counter 0");
  resp1_ctr_a: assert property (@(posedge clk) disable iff (srst) // [R7]
    (cfg.evCode == pesd_pkg::EV_RESP1 && cfg.counterSel != 2'h3) |-> !allowed)
    else $error("response event 1 accepted off counter 3");
  precise_ctr_a: assert property (@(posedge clk) disable iff (srst) // [R11]
    (cfg.evCode == pesd_pkg::EV_IRET && u == 8'h01
     && cfg.counterSel != 2'h1) |-> !allowed)
    else $error("precise retire accepted off counter 1");
  disp_add_a: assert property (@(posedge clk) disable iff (srst) // [R3]
    (cfg.enable && !cfg.countClear && cfg.evCode == pesd_pkg::EV_DISP
     && u == 8'h01 && cfg.cmask == 8'h00)
    |=> count_reg == $past(count_reg) + CW'($past(uopsDispThread)))
    else $error("thread dispatch count not added");
  stall_cnt_a: assert property (@(posedge clk) disable iff (srst) // [R3]
    (cfg.enable && !cfg.countClear && cfg.evCode == pesd_pkg::EV_DISP
     && u == 8'h01 && cfg.cmask == 8'h01 && cfg.thresholdInvert
     && uopsDispThread == 4'h0)
    |=> count_reg == $past(count_reg) + 1)
    else $error("stall cycle not counted");
  core_disp_a: assert property (@(posedge clk) disable iff (srst) // [R4]
    (cfg.enable && !cfg.countClear && cfg.evCode == pesd_pkg::EV_DISP
     && u == 8'h02 && cfg.cmask == 8'h00)
    |=> count_reg == $past(count_reg) + CW'($past(uopsDispCore)))
    else $error("core dispatch count not added");
  fp_any_a: assert property (@(posedge clk) disable iff (srst) // [R17]
    (cfg.enable && !cfg.countClear && cfg.evCode == pesd_pkg::EV_FPA
     && u == 8'h1e && cfg.cmask == 8'h00 && |evt[33:30])
    |=> count_reg == $past(count_reg) + 1)
    else $error("any-assist cycle not counted");
  itlb_a: assert property (@(posedge clk) disable iff (srst) // [R1]
    (cfg.enable && !cfg.countClear && cfg.evCode == pesd_pkg::EV_ITLB
     && u == 8'h01 && cfg.cmask == 8'h00 && evt[0])
    |=> count_reg == $past(count_reg) + 1)
    else $error("flush not counted");
endmodule : pesd_event_core
`default_nettype wire

/* File: pesd_pkg.sv */
// package: constants for the performance event select decoder
package pesd_pkg;
  // event codes
  localparam logic [7:0] EV_ITLB   = 8'hae;
  localparam logic [7:0] EV_OFFREQ = 8'hb0;
  localparam logic [7:0] EV_DISP   = 8'hb1;
  localparam logic [7:0] EV_BUFFUL = 8'hb2;
  localparam logic [7:0] EV_PGX    = 8'hb6;
  localparam logic [7:0] EV_RESP0  = 8'hb7;
  localparam logic [7:0] EV_RESP1  = 8'hbb;
  localparam logic [7:0] EV_XFLUSH = 8'hbd;
  localparam logic [7:0] EV_BANK   = 8'hbf;
  localparam logic [7:0] EV_IRET   = 8'hc0;
  localparam logic [7:0] EV_OTHA   = 8'hc1;
  localparam logic [7:0] EV_URET   = 8'hc2;
  localparam logic [7:0] EV_MCLR   = 8'hc3;
  localparam logic [7:0] EV_BRET   = 8'hc4;
  localparam logic [7:0] EV_BMISP  = 8'hc5;
  localparam logic [7:0] EV_FPA    = 8'hca;
  // filter register addresses that the off-core response events depend on
  localparam logic [15:0] RESP0_FILTER = 16'h01a6;
  localparam logic [15:0] RESP1_FILTER = 16'h01a7;
  // counter numbers bound to restricted events
  localparam logic [1:0] CNT_RESP0   = 2'h0;
  localparam logic [1:0] CNT_PRECISE = 2'h1;
  localparam logic [1:0] CNT_RESP1   = 2'h3;
  // register map (byte addresses)
  localparam logic [7:0] A_SEL    = 8'h00;
  localparam logic [7:0] A_COUNT  = 8'h04;
  localparam logic [7:0] A_STATUS = 8'h08;
  localparam logic [7:0] A_FILT   = 8'h0c;
  localparam logic [31:0] SEL_RST = 32'h0000_0000;
  // select register fields
  localparam int SEL_EV_LSB   = 0;
  localparam int SEL_UM_LSB   = 8;
  localparam int SEL_CM_LSB   = 16;
  localparam int SEL_INV_BIT  = 24;
  localparam int SEL_EN_BIT   = 25;
  localparam int SEL_CNT_LSB  = 26;
  localparam logic [1:0] RESP_NONE = 2'h0;
  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : pesd_pkg

/* File: pesd_cfg_if.sv */
// interface: decoded selection passed from the bus slave to the decoder
`timescale 1ns/1ps
`default_nettype none
interface pesd_cfg_if;
  logic [7:0]  evCode;
  logic [7:0]  unitMask;
  logic [7:0]  cmask;
  logic        thresholdInvert;
  logic        enable;
  logic [1:0]  counterSel;
  logic [1:0]  filterOk;
  logic        countClear;
  logic [47:0] count;
  logic        accepted;
  modport slave (output evCode, unitMask, cmask, thresholdInvert, enable,
                 counterSel, filterOk, countClear,
                 input count, accepted);
  modport core  (input evCode, unitMask, cmask, thresholdInvert, enable,
                 counterSel, filterOk, countClear,
                 output count, accepted);
endinterface : pesd_cfg_if
`default_nettype wire

/* File: pesd_axil_slave.sv */
// module: axi4-lite register slave holding the event selection
`timescale 1ns/1ps
`default_nettype none
module pesd_axil_slave (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  pesd_cfg_if.slave        cfg
);
  logic [31:0] sel_reg;
  logic [1:0]  filt_reg;
  logic        awHeld;
  logic        wHeld;
  logic [7:0]  awAddrReg;
  logic [31:0] wDataReg;
  logic [3:0]  wStrbReg;
  logic        clr_reg;
  logic [31:0] merged;

  assign awready = !awHeld && !bvalid;
  assign wready  = !wHeld && !bvalid;
  assign arready = !rvalid;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      merged[i*8 +: 8] = wStrbReg[i] ? wDataReg[i*8 +: 8] : sel_reg[i*8 +: 8];
    end
  end

  // address and data may arrive in either order; the write fires with both
  always_ff @(posedge clk) begin
    if (srst) begin
      awHeld    <= 1'b0;
      wHeld     <= 1'b0;
      awAddrReg <= 8'h00;
      wDataReg  <= 32'h0;
      wStrbReg  <= 4'h0;
      bvalid    <= 1'b0;
      bresp     <= pesd_pkg::RESP_OKAY;
      sel_reg   <= pesd_pkg::SEL_RST;
      filt_reg  <= 2'h0;
      clr_reg   <= 1'b0;
    end else begin
      clr_reg <= 1'b0;
      if (awvalid && awready) begin
        awHeld    <= 1'b1;
        awAddrReg <= awaddr;
      end
      if (wvalid && wready) begin
        wHeld    <= 1'b1;
        wDataReg <= wdata;
        wStrbReg <= wstrb;
      end
      if (awHeld && wHeld) begin
        awHeld <= 1'b0;
        wHeld  <= 1'b0;
        bvalid <= 1'b1;
        bresp  <= pesd_pkg::RESP_OKAY;
        if (awAddrReg[7:2] == pesd_pkg::A_SEL[7:2]) begin
          sel_reg <= merged;
        end else if (awAddrReg[7:2] == pesd_pkg::A_COUNT[7:2]) begin
          clr_reg <= 1'b1;
        end else if (awAddrReg[7:2] == pesd_pkg::A_FILT[7:2]) begin
          if (wStrbReg[0]) begin
            filt_reg <= wDataReg[1:0];
          end
        end else if (awAddrReg[7:2] != pesd_pkg::A_STATUS[7:2]) begin
          bresp <= pesd_pkg::RESP_SLVERR;
        end
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0;
      rresp  <= pesd_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp  <= pesd_pkg::RESP_OKAY;
      if (araddr[7:2] == pesd_pkg::A_SEL[7:2]) begin
        rdata <= sel_reg;
      end else if (araddr[7:2] == pesd_pkg::A_COUNT[7:2]) begin
        rdata <= cfg.count[31:0];
      end else if (araddr[7:2] == pesd_pkg::A_STATUS[7:2]) begin
        rdata <= {15'h0, cfg.accepted, cfg.count[47:32]};
      end else if (araddr[7:2] == pesd_pkg::A_FILT[7:2]) begin
        rdata <= {30'h0, filt_reg};
      end else begin
        rdata <= 32'h0;
        rresp <= pesd_pkg::RESP_SLVERR;
      end
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  assign cfg.evCode          = sel_reg[pesd_pkg::SEL_EV_LSB +: 8];
  assign cfg.unitMask        = sel_reg[pesd_pkg::SEL_UM_LSB +: 8];
  assign cfg.cmask           = sel_reg[pesd_pkg::SEL_CM_LSB +: 8];
  assign cfg.thresholdInvert = sel_reg[pesd_pkg::SEL_INV_BIT];
  assign cfg.enable          = sel_reg[pesd_pkg::SEL_EN_BIT];
  assign cfg.counterSel      = sel_reg[pesd_pkg::SEL_CNT_LSB +: 2];
  assign cfg.filterOk        = filt_reg;
  assign cfg.countClear      = clr_reg;
endmodule : pesd_axil_slave
`default_nettype wire

/* File: pesd_top.sv */
// top: performance event select decoder with axi4-lite registers
// Notes on behaviour
// [R1] ae/01 counts instruction translation flushes
// [R2] b0 counts demand reads, ownership, all reads
// [R3] b1/01 adds thread dispatches; cmask1+invert stalls
// [R4] b1/02 adds core dispatches, no any-thread
// [R5] b2/01 counts request buffer full
// [R6] b6 counts page-crossing offset loads
// [R7] b7 counter0 filter a6; bb counter3 a7
// [R8] bd counts data/second-level flush attempts
// [R9] bf/05 with cmask1 counts bank conflicts
// [R10] c0/00 counts retired instructions
// [R11] c0/01 only counter1, others quiesced
// [R12] c1 counts miss, store assist, transitions
// [R13] c2 retired uops and retirement slots
// [R14] c3 machine clears by unit mask
// [R15] c4 retired branches by unit mask
// [R16] c5 mispredicted retired branches by mask
// [R17] ca float assists, 1e any-assist cycles
// [R18] undefined selections leave counter unchanged
// [R19] add occurrences, or qualifying cycles
`timescale 1ns/1ps
`default_nettype none
module pesd_top (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [3:0]  uopsDispThread,
  input  wire logic [3:0]  uopsDispCore,
  input  wire logic [3:0]  uopsRetired,
  input  wire logic [3:0]  retireSlots,
  input  wire logic [3:0]  instrRetired,
  input  wire logic [63:0] evt,
  input  wire logic        otherCountersIdle
);
  pesd_cfg_if cfgBus ();

  pesd_axil_slave uSlave (
    .clk     (clk),
    .srst    (srst),
    .awaddr  (s_axi_awaddr),
    .awvalid (s_axi_awvalid),
    .awready (s_axi_awready),
    .wdata   (s_axi_wdata),
    .wstrb   (s_axi_wstrb),
    .wvalid  (s_axi_wvalid),
    .wready  (s_axi_wready),
    .bresp   (s_axi_bresp),
    .bvalid  (s_axi_bvalid),
    .bready  (s_axi_bready),
    .araddr  (s_axi_araddr),
    .arvalid (s_axi_arvalid),
    .arready (s_axi_arready),
    .rdata   (s_axi_rdata),
    .rresp   (s_axi_rresp),
    .rvalid  (s_axi_rvalid),
    .rready  (s_axi_rready),
    .cfg     (cfgBus)
  );

  pesd_event_core #(.CW(48)) uCore (
    .clk               (clk),
    .srst              (srst),
    .uopsDispThread    (uopsDispThread),
    .uopsDispCore      (uopsDispCore),
    .uopsRetired       (uopsRetired),
    .retireSlots       (retireSlots),
    .instrRetired      (instrRetired),
    .evt               (evt),
    .otherCountersIdle (otherCountersIdle),
    .cfg               (cfgBus)
  );
endmodule : pesd_top
`default_nettype wire

/* File: pesd_core_model.sv */
// model: core pipeline side driving event pulses and per-cycle counts
`timescale 1ns/1ps
`default_nettype none
module pesd_core_model (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        go,
  input  wire logic [63:0] pat,
  input  wire logic [3:0]  lv,
  output logic [63:0]      evt,
  output logic [3:0]       dThr,
  output logic [3:0]       dCore,
  output logic [3:0]       uRet,
  output logic [3:0]       slots,
  output logic [3:0]       iRet
);
  // pulses last one cycle; level ports carry lv times 1, 2 or 4, so a source of the wrong scale shows
  always_ff @(posedge clk) begin
    if (srst) begin
      evt <= 64'h0;
    end else begin
      evt <= go ? pat : 64'h0;
    end
  end
  // lv must stay below 4 so the shifted copies do not wrap
  always_ff @(posedge clk) begin
    dThr  <= srst ? 4'h0 : lv;
    dCore <= srst ? 4'h0 : {lv[2:0], 1'b0};
    uRet  <= srst ? 4'h0 : lv;
    slots <= srst ? 4'h0 : {lv[2:0], 1'b0};
    iRet  <= srst ? 4'h0 : {lv[1:0], 2'h0};
  end
endmodule // pesd_core_model
`default_nettype wire

/* File: pesd_top_tb.sv */
// testbench: event selection, restriction and threshold checks
`timescale 1ns/1ps
`default_nettype none
module pesd_top_tb;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [7:0]  awaddr = 8'h00;
  logic        awvalid = 1'b0;
  logic        awready;
  logic [31:0] wdata = 32'h0;
  logic        wvalid = 1'b0;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready = 1'b0;
  logic [7:0]  araddr = 8'h00;
  logic        arvalid = 1'b0;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready = 1'b0;
  logic        go = 1'b0;
  logic [63:0] pat = 64'h0;
  logic [3:0]  lv = 4'h0;
  logic        idle = 1'b1;
  logic [63:0] evt;
  logic [3:0]  dThr, dCore, uRet, slots, iRet;
  logic [1:0]  rs;
  logic [31:0] rv;
  int          errTotal = 0;
  int          nCompared = 0;
  localparam logic [23:0] TBL [0:34] = '{
    24'hae0100,
    24'hb00101, 24'hb00402, 24'hb00803,
    24'hb20104, 24'hb60105,
    24'hb70106, 24'hbb0107,
    24'hbd0108, 24'hbd2009,
    24'hc1020b, 24'hc1080c, 24'hc1100d, 24'hc1200e,
    24'hc3020f, 24'hc30410, 24'hc32011,
    24'hc40012, 24'hc40412, 24'hc40113, 24'hc40214, 24'hc40815,
    24'hc41016, 24'hc42017, 24'hc44018,
    24'hc50019, 24'hc50419, 24'hc5011a, 24'hc5021b, 24'hc5101c,
    24'hc5201d, 24'hca021e, 24'hca041f, 24'hca0820, 24'hca1021};

  always #2.5 clk = ~clk;

  pesd_core_model core (.clk(clk), .srst(srst), .go(go), .pat(pat),
    .lv(lv), .evt(evt), .dThr(dThr), .dCore(dCore), .uRet(uRet),
    .slots(slots), .iRet(iRet));

  pesd_top dut (.clk(clk), .srst(srst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .uopsDispThread(dThr), .uopsDispCore(dCore),
    .uopsRetired(uRet), .retireSlots(slots), .instrRetired(iRet),
    .evt(evt), .otherCountersIdle(idle));

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    nCompared++;
    if (g !== e) begin
      errTotal++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // no cycle limit here: only the watchdog ends a hung wait
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (bvalid === 1'b1) break;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end
    rs = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic axr(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (rvalid === 1'b1) break;
      if (arready === 1'b1) arvalid <= 1'b0;
    end
    rv = rdata;
    rs = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask

  // selecting first, then clearing, wipes anything counted meanwhile
  task automatic sel(input logic [7:0] ev, um, cm, input logic threshold_invert,
                     input logic [1:0] cn);
    axw(pesd_pkg::A_SEL, {4'h0, cn, 1'b1, threshold_invert, cm, um, ev});
    axw(pesd_pkg::A_COUNT, 32'h0);
  endtask

  task automatic expect_count(input logic [31:0] e, input logic acc);
    repeat (3) @(posedge clk);
    axr(pesd_pkg::A_COUNT);
    chk("count", e, rv);
    axr(pesd_pkg::A_STATUS);
    chk("status", {15'h0, acc, 16'h0}, rv);
  endtask

  task automatic pulse(input logic [63:0] p, input int n);
    repeat (n) begin
      go <= 1'b1;
      pat <= p;
      @(posedge clk);
      go <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask

  task automatic lvcase(input logic [7:0] ev, um, cm,
                        input logic [1:0] cn, input logic [31:0] e);
    sel(ev, um, cm, 1'b0, cn);
    lv <= 4'h3;
    repeat (5) @(posedge clk);
    lv <= 4'h0;
    @(posedge clk);
    expect_count(e, 1'b1);
  endtask

  // precise retire refused: wrong counter or others not quiesced
  task automatic lvrefuse(input logic [1:0] cn);
    sel(8'hc0, 8'h01, 8'h0, 1'b0, cn);
    lv <= 4'h3;
    repeat (5) @(posedge clk);
    lv <= 4'h0;
    expect_count(32'h0, 1'b0);
  endtask

  task automatic run_bus;
    axr(pesd_pkg::A_SEL);
    chk("sel reset", pesd_pkg::SEL_RST, rv);
    axr(8'h10);
    chk("unmapped rresp", {30'h0, pesd_pkg::RESP_SLVERR}, {30'h0, rs});
    chk("unmapped rdata", 32'h0, rv);
    axw(8'h10, 32'h1);
    chk("unmapped bresp", {30'h0, pesd_pkg::RESP_SLVERR}, {30'h0, rs});
    axw(pesd_pkg::A_FILT, 32'h3);
    axr(pesd_pkg::A_FILT);
    chk("filter", 32'h3, rv);
    $display("test bus done");
  endtask

  // decoy pulse on the next bit must not be counted
  task automatic run_table;
    int i;
    logic [7:0] b;
    for (i = 0; i < 35; i++) begin
      b = TBL[i][7:0];
      sel(TBL[i][23:16], TBL[i][15:8], 8'h0, 1'b0,
          (TBL[i][23:16] == 8'hbb) ? 2'h3 : 2'h0);
      pulse(64'h1 << b, 2);
      pulse(64'h1 << ((b + 8'h1) % 8'd34), 1);
      expect_count(32'h2, 1'b1);
    end
    sel(8'hbf, 8'h05, 8'h1, 1'b0, 2'h0);
    pulse(64'h1 << 10, 2);
    expect_count(32'h2, 1'b1);
    sel(8'hca, 8'h1e, 8'h0, 1'b0, 2'h0);
    pulse((64'h1 << 30) | (64'h1 << 33), 2);
    expect_count(32'h2, 1'b1);
    $display("test table done");
  endtask

  task automatic run_levels;
    lvcase(8'hb1, 8'h01, 8'h0, 2'h0, 32'd15);
    lvcase(8'hb1, 8'h02, 8'h0, 2'h0, 32'd30);
    lvcase(8'hc2, 8'h01, 8'h0, 2'h0, 32'd15);
    lvcase(8'hc2, 8'h02, 8'h0, 2'h0, 32'd30);
    lvcase(8'hc0, 8'h00, 8'h0, 2'h0, 32'd60);
    lvcase(8'hc0, 8'h01, 8'h0, 2'h1, 32'd60);
    lvcase(8'hc2, 8'h01, 8'h1, 2'h0, 32'd5);
    lvcase(8'hb1, 8'h02, 8'h6, 2'h0, 32'd5);
    lvcase(8'hb1, 8'h02, 8'h7, 2'h0, 32'd0);
    $display("test levels done");
  endtask

  // dispatch held on around a gap of exactly 7 idle cycles
  task automatic run_stall;
    lv <= 4'h3;
    sel(8'hb1, 8'h01, 8'h1, 1'b1, 2'h0);
    lv <= 4'h0;
    repeat (7) @(posedge clk);
    lv <= 4'h3;
    expect_count(32'd7, 1'b1);
    lv <= 4'h0;
    @(posedge clk);
    $display("test stall done");
  endtask

  task automatic run_refuse;
    sel(8'hb7, 8'h01, 8'h0, 1'b0, 2'h2);
    pulse(64'h1 << 6, 2);
    expect_count(32'h0, 1'b0);
    sel(8'hbb, 8'h01, 8'h0, 1'b0, 2'h0);
    pulse(64'h1 << 7, 2);
    expect_count(32'h0, 1'b0);
    lvrefuse(2'h2);
    idle <= 1'b0;
    lvrefuse(2'h1);
    idle <= 1'b1;
    axw(pesd_pkg::A_FILT, 32'h0);
    sel(8'hb7, 8'h01, 8'h0, 1'b0, 2'h0);
    pulse(64'h1 << 6, 2);
    expect_count(32'h0, 1'b0);
    sel(8'hae, 8'h02, 8'h0, 1'b0, 2'h0);
    pulse(64'h1, 2);
    expect_count(32'h0, 1'b0);
    sel(8'hcc, 8'h01, 8'h0, 1'b0, 2'h0);
    pulse(64'h3, 2);
    expect_count(32'h0, 1'b0);
    $display("test refuse done");
  endtask

  task automatic final_report;
    $display("compared %0d mismatches %0d", nCompared, errTotal);
    if (errTotal == 0 && nCompared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // idle stands for software quiescing the other counters
  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    run_bus();
    run_table();
    run_levels();
    run_stall();
    run_refuse();
    final_report();
  end

  initial begin
    repeat (30000) @(posedge clk);
    errTotal++;
    final_report();
  end
endmodule // pesd_top_tb
`default_nettype wire
